// *** design/sacs_consts.vh ***
// Constants for the converter channel sequencer
//
// Contract
// - Converter clock at most 18 MHz; each conversion spends at least 18 clocks.
// - Every conversion yields a 12-bit result.
// - Reduced-rate variant throughput capped at 806 thousand samples per second.
// - Reference select picks supply, half supply, 1.024 V or external pin.
// - Sample-and-hold acquisition length is programmable.
// - Eight inputs multiplexed; enabled channels scanned without processor help.
// - No idle cycles between channels; aggregate rate equals single-channel rate.
// - Channel chosen by scan state machine or directly by firmware.
// - Latest result of every channel held in its own buffer.
// - Each channel has its own sample time, applied when converted.
// - Result outside low/high limits raises out-of-range interrupt immediately.
// - On-chip temperature sensor selectable as conversion input.
// - Converter does not run in the two deepest low-power modes.
`ifndef SACS_CONSTS_VH
`define SACS_CONSTS_VH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define SACS_RES_BITS 12
`define SACS_NCHAN 8
`define SACS_CHAN_BITS 3
`define SACS_STIME_BITS 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define SACS_CLK_HZ 10000000
`define SACS_MAX_CONV_HZ 18000000
`define SACS_MIN_CONV_CLKS 18
`define SACS_CONV_CLKS 14
`define SACS_MIN_SAMPLE_CLKS 4
`define SACS_RED_SPS 806000
`define SACS_RED_CLKS ((`SACS_CLK_HZ + `SACS_RED_SPS - 1) / `SACS_RED_SPS)

// ----------------------------------------
// Reference select codes
// ----------------------------------------
`define SACS_REF_VDD 2'h0
`define SACS_REF_VDD_HALF 2'h1
`define SACS_REF_INTERNAL 2'h2
`define SACS_REF_EXTERNAL 2'h3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SACS_RST_CODE 12'h800
`define SACS_RST_REF 2'h0

`endif

// *** design/sacs_result_mem.v ***
// Per-channel result buffer with registered read data
module sacs_result_mem #(
  parameter DW = 12,
  parameter AW = 3
) (
  input wire mclk, // Clock
  input wire arst_n, // Async reset, active low
  input wire wr_en, // Write strobe
  input wire [AW-1:0] wr_addr, // Write channel
  input wire [DW-1:0] wr_data, // Write result
  input wire [AW-1:0] rd_addr, // Read channel
  output reg [DW-1:0] rd_data_q // Registered read data
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read register lags the address by one clock
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= {DW{1'b0}};
    end else begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule

// *** design/sacs_top.v ***
// Sequencer and successive-approximation control for the 12-bit converter
`include "sacs_consts.vh"

module sacs_top #(
  parameter REDUCED_RATE = 0
) (
  input wire mclk, // Converter clock, 10 MHz
  input wire arst_n, // Async reset, active low
  input wire sar_enable, // Converter enable
  input wire auto_scan, // 1 scan machine, 0 firmware select
  input wire scan_start, // Start a scan, pulse
  input wire scan_continuous, // Restart scan after completion
  input wire [7:0] chan_enable, // Channels in the scan
  input wire [2:0] fw_chan, // Firmware-selected channel
  input wire fw_start, // Convert fw_chan once, pulse
  input wire temp_sel, // Route temperature sensor in place of channel 7
  input wire [1:0] ref_select, // Reference choice
  input wire [63:0] sample_times, // Eight 8-bit sample times, channel 0 lowest
  input wire [11:0] limit_low, // Low range limit
  input wire [11:0] limit_high, // High range limit
  input wire [7:0] range_mask, // Interrupt enable per channel
  input wire [7:0] range_clear, // Clear range flags, pulse per bit
  input wire deep_sleep, // Deep Sleep mode level
  input wire hibernate, // Hibernate mode level
  input wire cmp_in, // Analog comparator: input at or above trial code
  input wire [2:0] rd_chan, // Result read channel
  output reg [2:0] mux_sel_q, // Converter input multiplexer select
  output reg temp_route_q, // Temperature sensor routed to converter
  output reg [1:0] ref_sel_q, // Reference select to analog
  output reg sample_q, // Sample-and-hold tracking
  output reg [11:0] trial_code_q, // Capacitor DAC trial code
  output reg busy_q, // Conversion or scan active
  output reg conv_done_q, // Result ready, one-cycle pulse
  output reg [2:0] conv_chan_q, // Channel of last result
  output reg [11:0] conv_result_q, // Last result
  output reg scan_done_q, // Scan complete, one-cycle pulse
  output wire [11:0] rd_data_q, // Buffered result of rd_chan
  output reg [7:0] range_flags_q, // Sticky out-of-range flags
  output reg range_irq_q // Out-of-range interrupt request
);
  // ----------------------------------------
  // States and derived timing
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SAMPLE = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // Throughput floor; the reduced-rate part may need more clocks per sample
  localparam integer RED_CLKS = `SACS_RED_CLKS;
  localparam integer MIN_TOTAL = (REDUCED_RATE != 0 && RED_CLKS > `SACS_MIN_CONV_CLKS) ?
                                 RED_CLKS : `SACS_MIN_CONV_CLKS;
  localparam integer FLOOR_SAMP = MIN_TOTAL - `SACS_CONV_CLKS;
  localparam integer MIN_SAMP = (FLOOR_SAMP > `SACS_MIN_SAMPLE_CLKS) ?
                                FLOOR_SAMP : `SACS_MIN_SAMPLE_CLKS;
  localparam [7:0] MIN_SAMP8 = MIN_SAMP[7:0];
  localparam integer LAST_CONV_I = `SACS_CONV_CLKS - 1;
  localparam [3:0] LAST_CONV = LAST_CONV_I[3:0];

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Lowest enabled channel above cur (or from 0 when first); bit 3 = found
  function [3:0] next_chan;
    input [7:0] en;
    input [2:0] cur;
    input first;
    integer i;
    begin
      next_chan = 4'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        if (en[i] && (first || i > cur)) begin
          next_chan = {1'b1, i[2:0]};
        end
      end
    end
  endfunction

  // Programmed sample time, never below the floor
  function [7:0] samp_len;
    input [63:0] times;
    input [2:0] ch;
    reg [7:0] t;
    begin
      t = times[ch*8 +: 8];
      samp_len = (t < MIN_SAMP8) ? MIN_SAMP8 : t;
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] state_q, state_d;
  reg [7:0] cnt_q, cnt_d;
  reg scan_q, scan_d;
  reg [2:0] mux_d;
  reg [11:0] code_d;
  reg conv_done_d, scan_done_d, wr_en;
  reg [11:0] result;
  reg [3:0] nxt, first_ch;
  reg [7:0] oor;
  wire halt = deep_sleep | hibernate | ~sar_enable;

  // ----------------------------------------
  // Sequencer and approximation
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    scan_d = scan_q;
    mux_d = mux_sel_q;
    code_d = trial_code_q;
    conv_done_d = 1'b0;
    scan_done_d = 1'b0;
    wr_en = 1'b0;
    result = trial_code_q;
    nxt = next_chan(chan_enable, mux_sel_q, 1'b0);
    first_ch = next_chan(chan_enable, 3'h0, 1'b1);
    case (state_q)
      ST_IDLE: begin
        if (auto_scan && scan_start && first_ch[3]) begin
          state_d = ST_SAMPLE;
          scan_d = 1'b1;
          mux_d = first_ch[2:0];
          cnt_d = samp_len(sample_times, first_ch[2:0]) - 8'h01;
        end else if (!auto_scan && fw_start) begin
          state_d = ST_SAMPLE;
          scan_d = 1'b0;
          mux_d = fw_chan;
          cnt_d = samp_len(sample_times, fw_chan) - 8'h01;
        end
      end
      ST_SAMPLE: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h00) begin
          state_d = ST_CONV;
          // Restart from zero so the conversion phase is exactly the fixed count
          cnt_d = 8'h00;
          code_d = `SACS_RST_CODE;
        end
      end
      ST_CONV: begin
        cnt_d = cnt_q + 8'h01;
        // Twelve trial cycles, MSB first, then two settle cycles
        if (cnt_q < 8'd12) begin
          code_d[4'd11 - cnt_q[3:0]] = cmp_in;
          if (cnt_q < 8'd11) begin
            code_d[4'd10 - cnt_q[3:0]] = 1'b1;
          end
        end
        if (cnt_q[3:0] == LAST_CONV) begin
          wr_en = 1'b1;
          conv_done_d = 1'b1;
          state_d = ST_IDLE;
          if (scan_q && nxt[3]) begin
            state_d = ST_SAMPLE;
            mux_d = nxt[2:0];
            cnt_d = samp_len(sample_times, nxt[2:0]) - 8'h01;
          end else if (scan_q) begin
            scan_done_d = 1'b1;
            if (scan_continuous && first_ch[3]) begin
              state_d = ST_SAMPLE;
              mux_d = first_ch[2:0];
              cnt_d = samp_len(sample_times, first_ch[2:0]) - 8'h01;
            end else begin
              scan_d = 1'b0;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Low-power modes stop the converter clock, so abandon any conversion
    if (halt) begin
      state_d = ST_IDLE;
      scan_d = 1'b0;
      wr_en = 1'b0;
      conv_done_d = 1'b0;
      scan_done_d = 1'b0;
    end
  end

  // ----------------------------------------
  // Range check
  // ----------------------------------------
  always @* begin
    oor = 8'h00;
    if (wr_en && (result < limit_low || result > limit_high)) begin
      oor[mux_sel_q] = 1'b1;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      scan_q <= 1'b0;
      mux_sel_q <= 3'h0;
      temp_route_q <= 1'b0;
      ref_sel_q <= `SACS_RST_REF;
      sample_q <= 1'b0;
      trial_code_q <= `SACS_RST_CODE;
      busy_q <= 1'b0;
      conv_done_q <= 1'b0;
      conv_chan_q <= 3'h0;
      conv_result_q <= 12'h000;
      scan_done_q <= 1'b0;
      range_flags_q <= 8'h00;
      range_irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      scan_q <= scan_d;
      mux_sel_q <= mux_d;
      temp_route_q <= temp_sel && (mux_d == 3'h7);
      ref_sel_q <= ref_select;
      sample_q <= (state_d == ST_SAMPLE);
      trial_code_q <= code_d;
      busy_q <= (state_d != ST_IDLE);
      conv_done_q <= conv_done_d;
      scan_done_q <= scan_done_d;
      if (wr_en) begin
        conv_chan_q <= mux_sel_q;
        conv_result_q <= result;
      end
      // New event wins over a clear in the same cycle
      range_flags_q <= (range_flags_q & ~range_clear) | oor;
      range_irq_q <= |(((range_flags_q & ~range_clear) | oor) & range_mask);
    end
  end

  // ----------------------------------------
  // Result buffer
  // ----------------------------------------
  sacs_result_mem #(
    .DW(`SACS_RES_BITS),
    .AW(`SACS_CHAN_BITS)
  ) u_mem (
    .mclk(mclk),
    .arst_n(arst_n),
    .wr_en(wr_en),
    .wr_addr(mux_sel_q),
    .wr_data(result),
    .rd_addr(rd_chan),
    .rd_data_q(rd_data_q)
  );
endmodule

// *** verification/sacs_properties.sv ***
// Port checker for the converter channel sequencer
module sacs_props (
  input wire mclk,
  input wire arst_n,
  input wire auto_scan,
  input wire [1:0] ref_select,
  input wire [7:0] range_mask,
  input wire [7:0] range_clear,
  input wire [2:0] mux_sel_q,
  input wire temp_route_q,
  input wire [1:0] ref_sel_q,
  input wire sample_q,
  input wire [11:0] trial_code_q,
  input wire busy_q,
  input wire conv_done_q,
  input wire scan_done_q,
  input wire [7:0] range_flags_q,
  input wire range_irq_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  a_conv_min_len: assert property ($rose(busy_q) |->
    (!conv_done_q)[*8] ##1 (!conv_done_q)[*8] ##1 !conv_done_q) else $error("short conversion");
  a_trial_msb_first: assert property ($fell(sample_q) && busy_q |-> trial_code_q == 12'h800)
    else $error("bad first trial");
  a_ref_follow: assert property (ref_sel_q == $past(ref_select))
    else $error("reference select lag");
  a_hold_to_result: assert property ($fell(sample_q) && busy_q |-> ##14 conv_done_q)
    else $error("conversion phase length");
  a_scan_no_idle: assert property (conv_done_q && auto_scan && !scan_done_q |=> sample_q)
    else $error("idle gap in scan");
  a_done_busy: assert property (conv_done_q |-> $past(busy_q))
    else $error("result while idle");
  a_temp_ch7: assert property (temp_route_q |-> mux_sel_q == 3'h7)
    else $error("sensor on wrong channel");
  a_flag_set_cause: assert property (|(range_flags_q & ~$past(range_flags_q)) |-> conv_done_q)
    else $error("flag set without result");
  a_flag_sticky: assert property ((~range_flags_q & $past(range_flags_q & ~range_clear)) == 8'h00)
    else $error("flag dropped");
  a_irq_level: assert property (range_irq_q == |(range_flags_q & $past(range_mask)))
    else $error("irq mismatch");
  a_scan_last: assert property (scan_done_q |-> conv_done_q)
    else $error("scan end without result");
endmodule

bind sacs_top sacs_props u_props (.mclk, .arst_n, .auto_scan, .ref_select, .range_mask,
  .range_clear, .mux_sel_q, .temp_route_q, .ref_sel_q, .sample_q, .trial_code_q, .busy_q,
  .conv_done_q, .scan_done_q, .range_flags_q, .range_irq_q);

// *** verification/sacs_analog_model.sv ***
// Behavioural analog side: pins, temperature sensor and comparator
module sacs_analog_model (
  input wire logic [2:0] mux_sel_q, // Selected channel
  input wire logic temp_route_q, // Sensor routed
  input wire logic [11:0] trial_code_q, // Trial code
  input wire logic [95:0] vin_bus, // Pin levels, channel 0 lowest
  input wire logic [11:0] vtemp, // Sensor level
  output wire logic cmp_in // Input at or above trial
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [11:0] level;
  assign level = temp_route_q ? vtemp : vin_bus[mux_sel_q*12 +: 12];
  assign cmp_in = level >= trial_code_q;
endmodule

// *** verification/tb_sar_adc_channel_sequencer.sv ***
// Self-checking bench for the converter channel sequencer
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("unexpected at %0t got %h exp %h", $time, a, b); end end
module tb_sar_adc_channel_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, arst_n = 0, sar_enable = 1, auto_scan = 0, scan_start = 0;
  logic scan_continuous = 0, fw_start = 0, temp_sel = 0, deep_sleep = 0, hibernate = 0;
  logic [7:0] chan_enable = 0, range_mask = 8'h01, range_clear = 0;
  logic [2:0] fw_chan = 0, rd_chan = 0, mux_sel_q, conv_chan_q;
  logic [1:0] ref_select = 0, ref_sel_q;
  logic [63:0] sample_times = 64'h09_00_04_00_04_06_00_02;
  logic [11:0] limit_low = 12'h100, limit_high = 12'h700, vtemp = 12'h555;
  logic [95:0] vin_bus = {12'hfff, 12'h000, 12'h7ff, 12'h000, 12'h700, 12'h3c3, 12'h000, 12'h0a5};
  logic [11:0] trial_code_q, conv_result_q, rd_data_q;
  logic [7:0] range_flags_q;
  logic cmp_in, temp_route_q, sample_q, busy_q, conv_done_q, scan_done_q, range_irq_q;
  int mismatches = 0, num_checks = 0;
  sacs_top u_dut (.mclk, .arst_n, .sar_enable, .auto_scan, .scan_start, .scan_continuous,
    .chan_enable, .fw_chan, .fw_start, .temp_sel, .ref_select, .sample_times, .limit_low,
    .limit_high, .range_mask, .range_clear, .deep_sleep, .hibernate, .cmp_in, .rd_chan,
    .mux_sel_q, .temp_route_q, .ref_sel_q, .sample_q, .trial_code_q, .busy_q, .conv_done_q,
    .conv_chan_q, .conv_result_q, .scan_done_q, .rd_data_q, .range_flags_q, .range_irq_q);
  sacs_analog_model u_ana (.mux_sel_q, .temp_route_q, .trial_code_q, .vin_bus, .vtemp, .cmp_in);
  always #50 mclk = ~mclk;
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Counts negedges until a result shows, bounded
  task automatic wait_done(output int n);
    n = 1;
    @(negedge mclk);
    while (conv_done_q !== 1'b1 && n < 300) begin
      @(negedge mclk);
      n++;
    end
  endtask
  task automatic fw_conv(input logic [2:0] ch, input logic [11:0] exp, input logic [7:0] fl,
                         input int dur);
    int n;
    fw_chan = ch;
    fw_start = 1;
    @(negedge mclk);
    fw_start = 0;
    wait_done(n);
    `CHK(n, dur)
    `CHK(conv_result_q, exp)
    `CHK(conv_chan_q, ch)
    `CHK(range_flags_q, fl)
    @(negedge mclk);
  endtask
  task automatic t_scan();
    int n;
    logic [2:0] order [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
    logic [11:0] exp [4] = '{12'h0a5, 12'h3c3, 12'h7ff, 12'h555};
    int dur [4] = '{18, 20, 18, 23};
    auto_scan = 1;
    temp_sel = 1;
    chan_enable = 8'ha5;
    scan_start = 1;
    @(negedge mclk);
    scan_start = 0;
    for (int i = 0; i < 4; i++) begin
      wait_done(n);
      `CHK(n, dur[i])
      `CHK(conv_chan_q, order[i])
      `CHK(conv_result_q, exp[i])
      `CHK(scan_done_q, 1'(i == 3))
    end
    @(negedge mclk);
    `CHK(busy_q, 1'b0)
    `CHK(range_flags_q, 8'h21)
    `CHK(range_irq_q, 1'b1)
    for (int i = 0; i < 4; i++) begin
      rd_chan = order[i];
      @(negedge mclk);
      `CHK(rd_data_q, exp[i])
    end
  endtask
  task automatic t_range();
    range_clear = 8'h01;
    @(negedge mclk);
    range_clear = 8'h00;
    `CHK(range_flags_q, 8'h20)
    `CHK(range_irq_q, 1'b0)
    range_mask = 8'h20;
    @(negedge mclk);
    `CHK(range_irq_q, 1'b1)
    range_mask = 8'h01;
  endtask
  task automatic t_cont();
    int n;
    chan_enable = 8'h08;
    scan_continuous = 1;
    scan_start = 1;
    @(negedge mclk);
    scan_start = 0;
    for (int i = 0; i < 3; i++) begin
      wait_done(n);
      `CHK(n, 18)
      `CHK(conv_chan_q, 3'h3)
      `CHK(conv_result_q, 12'h700)
      `CHK(scan_done_q, 1'b1)
      if (i == 1) scan_continuous = 0;
    end
    @(negedge mclk);
    `CHK(busy_q, 1'b0)
  endtask
  task automatic t_halt();
    // Abort a conversion while it samples
    fw_start = 1;
    @(negedge mclk);
    fw_start = 0;
    repeat (6) @(negedge mclk);
    `CHK(busy_q, 1'b1)
    deep_sleep = 1;
    @(negedge mclk);
    `CHK(busy_q, 1'b0)
    `CHK(conv_done_q, 1'b0)
    for (int k = 0; k < 3; k++) begin
      deep_sleep = (k == 0);
      hibernate = (k == 1);
      sar_enable = (k != 2);
      fw_start = 1;
      @(negedge mclk);
      fw_start = 0;
      repeat (3) @(negedge mclk);
      `CHK(busy_q, 1'b0)
    end
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1;
    @(negedge mclk);
    for (int i = 0; i < 4; i++) begin
      ref_select = i[1:0];
      @(negedge mclk);
      `CHK(ref_sel_q, i[1:0])
    end
    t_scan();
    t_range();
    t_cont();
    auto_scan = 0;
    temp_sel = 0;
    fw_conv(3'h3, 12'h700, 8'h20, 18);
    fw_conv(3'h7, 12'hfff, 8'ha0, 23);
    t_halt();
    report_and_stop();
  end
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
endmodule
